// ### hdl/packer_pkg.sv
// Constants, register map and types of the serial data packer.
// Assumes a single 50 MHz system clock.
package packer_pkg;

  // Clock and millisecond tick
  localparam int CLK_PERIOD_NS  = 20;
  localparam int MS_PERIOD_NS   = 1000000;
  localparam int MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Buffer and setting ranges
  localparam int BUF_DEPTH_DEFAULT = 1024;
  localparam int LEN_W             = 11;
  localparam int IDLE_W            = 16;
  localparam int PKT_CNT_W         = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] DELIM_OFS    = 8'h04;
  localparam logic [7:0] PACK_LEN_OFS = 8'h08;
  localparam logic [7:0] IDLE_MS_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] PKT_CNT_OFS  = 8'h14;

  // Field positions
  localparam int CTRL_D1_EN_BIT   = 0;
  localparam int CTRL_D2_EN_BIT   = 1;
  localparam int CTRL_MODE_LSB    = 4;
  localparam int DELIM_D1_LSB     = 0;
  localparam int DELIM_D2_LSB     = 8;
  localparam int STAT_COUNT_LSB   = 0;
  localparam int STAT_BUSY_BIT    = 16;
  localparam int STAT_REASON_LSB  = 20;

  // Reset values
  localparam logic [LEN_W-1:0]  PACK_LEN_RST = 11'h000;
  localparam logic [IDLE_W-1:0] IDLE_MS_RST  = 16'h0000;
  localparam logic [7:0]        DELIM_RST    = 8'h00;
  localparam logic              DELIM_EN_RST = 1'b0;

  // Release reason bits
  localparam int RSN_LEN   = 0;
  localparam int RSN_DELIM = 1;
  localparam int RSN_IDLE  = 2;
  localparam int RSN_FULL  = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DPROC_PASS  = 2'h0,
    DPROC_ADD1  = 2'h1,
    DPROC_ADD2  = 2'h2,
    DPROC_STRIP = 2'h3
  } dproc_t;

  typedef enum logic [2:0] {
    ST_FILL  = 3'h1,
    ST_FETCH = 3'h2,
    ST_SEND  = 3'h4
  } pack_state_t;

endpackage

// ### hdl/pack_buffer_mem.sv
// Port buffer storage: one write port, one registered read port.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/10ps
`default_nettype none
module pack_buffer_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Write port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input  wire logic             re_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset; only the output register does
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

// ### hdl/serial_data_packer.sv
// Serial data packer: buffers serial bytes, releases them as packets.
// Assumes serial bytes come from same-clock logic (a UART receiver) and
// registers are reached over AXI4-Lite on the same clock.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Packing length 0..1024, reset zero
// - Release when count reaches nonzero length
// - Length zero: no length release; full still releases
// - Two delimiters, each enable plus char
// - First delimiter alone triggers on match
// - Both enabled: first then second triggers
// - Full buffer always releases its contents
// - Four delimiter options, pass after reset
// - Option ignored without enabled delimiter
// - Pass: release now, delimiters kept
// - Add one: wait one more byte
// - Add two: wait two more bytes
// - Strip: release now, delimiters dropped
// - Idle timeout 0..65535 ms, reset zero
// - Release after idle time without bytes
// - Idle zero never releases on silence
module serial_data_packer
  import packer_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEFAULT,
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // Serial byte stream in
  input  wire logic [7:0]  ser_data_i,
  input  wire logic        ser_valid_i,
  output logic             ser_ready_o,
  // Network transmit stream out
  output logic [7:0]       tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i
);

  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam int AB_W  = $clog2(BUF_DEPTH);
  localparam int DIV_W = $clog2(MS_CYCLES);

  // Settings
  logic              d1_en, d2_en, next_d1_en, next_d2_en;
  dproc_t            mode, next_mode;
  logic [7:0]        d1_chr, d2_chr, next_d1_chr, next_d2_chr;
  logic [LEN_W-1:0]  pack_len, next_pack_len;
  logic [IDLE_W-1:0] idle_ms, next_idle_ms;

  // AXI state
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        have_aw, have_w, wr_go;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data, rd_word, wr_word;
  logic [3:0]  wr_strb;

  // Packer state
  pack_state_t           state, next_state;
  logic [CNT_W-1:0]      count, next_count, cnt_new, rd_ptr, next_rd_ptr;
  logic [CNT_W-1:0]      pkt_len, next_pkt_len, rel_len;
  logic [1:0]            extra, next_extra;
  logic                  prev_d1, next_prev_d1;
  logic [IDLE_W-1:0]     idle_cnt, next_idle_cnt;
  logic [DIV_W-1:0]      div_cnt, next_div_cnt;
  logic [PKT_CNT_W-1:0]  pkt_cnt, next_pkt_cnt;
  logic [3:0]            reason, next_reason, rel_why;
  logic                  acc, hit, strip, store, release_now, mem_re, ms_tick;

  // Byte-lane merge of a write into a register's current value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Register readback, shared by reads and strobed writes
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      CTRL_OFS: begin
        v[CTRL_D1_EN_BIT] = d1_en;
        v[CTRL_D2_EN_BIT] = d2_en;
        v[CTRL_MODE_LSB +: 2] = mode;
      end
      DELIM_OFS: begin
        v[DELIM_D1_LSB +: 8] = d1_chr;
        v[DELIM_D2_LSB +: 8] = d2_chr;
      end
      PACK_LEN_OFS: v = 32'(pack_len);
      IDLE_MS_OFS:  v = 32'(idle_ms);
      STATUS_OFS: begin
        v[STAT_COUNT_LSB +: CNT_W] = count;
        v[STAT_BUSY_BIT] = (state != ST_FILL);
        v[STAT_REASON_LSB +: 4] = reason;
      end
      PKT_CNT_OFS: v = 32'(pkt_cnt);
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == CTRL_OFS || a == DELIM_OFS || a == PACK_LEN_OFS || a == IDLE_MS_OFS ||
           a == STATUS_OFS || a == PKT_CNT_OFS;
  endfunction

  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o  = !w_held && !bvalid_o;
  assign arready_o = !rvalid_o;

  // Register bus: address and data taken in either order
  always_comb begin
    have_aw = aw_held || (awvalid_i && awready_o);
    have_w  = w_held || (wvalid_i && wready_o);
    wr_go   = have_aw && have_w;
    wr_addr = aw_held ? aw_addr : awaddr_i;
    wr_data = w_held ? w_data : wdata_i;
    wr_strb = w_held ? w_strb : wstrb_i;
    rd_word = reg_word(araddr_i);
    wr_word = merge(reg_word(wr_addr), wr_data, wr_strb);
    next_aw_held = aw_held || (awvalid_i && awready_o);
    next_aw_addr = (awvalid_i && awready_o) ? awaddr_i : aw_addr;
    next_w_held  = w_held || (wvalid_i && wready_o);
    next_w_data  = (wvalid_i && wready_o) ? wdata_i : w_data;
    next_w_strb  = (wvalid_i && wready_o) ? wstrb_i : w_strb;
    next_bvalid  = bvalid_o && !bready_i;
    next_bresp   = bresp_o;
    next_rvalid  = rvalid_o && !rready_i;
    next_rresp   = rresp_o;
    next_rdata   = rdata_o;
    next_d1_en    = d1_en;
    next_d2_en    = d2_en;
    next_mode     = mode;
    next_d1_chr   = d1_chr;
    next_d2_chr   = d2_chr;
    next_pack_len = pack_len;
    next_idle_ms  = idle_ms;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      case (wr_addr)
        CTRL_OFS: begin
          next_d1_en = wr_word[CTRL_D1_EN_BIT];
          next_d2_en = wr_word[CTRL_D2_EN_BIT];
          next_mode  = dproc_t'(wr_word[CTRL_MODE_LSB +: 2]);
        end
        DELIM_OFS: begin
          next_d1_chr = wr_word[DELIM_D1_LSB +: 8];
          next_d2_chr = wr_word[DELIM_D2_LSB +: 8];
        end
        PACK_LEN_OFS: next_pack_len = wr_word[LEN_W-1:0];
        IDLE_MS_OFS:  next_idle_ms  = wr_word[IDLE_W-1:0];
        default: next_bresp = next_bresp;
      endcase
    end
    if (arvalid_i && arready_o) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held  <= 1'b0;
      aw_addr  <= '0;
      w_held   <= 1'b0;
      w_data   <= '0;
      w_strb   <= '0;
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
      rvalid_o <= 1'b0;
      rresp_o  <= RESP_OKAY;
      rdata_o  <= '0;
      d1_en    <= DELIM_EN_RST;
      d2_en    <= DELIM_EN_RST;
      mode     <= DPROC_PASS;
      d1_chr   <= DELIM_RST;
      d2_chr   <= DELIM_RST;
      pack_len <= PACK_LEN_RST;
      idle_ms  <= IDLE_MS_RST;
    end else begin
      aw_held  <= next_aw_held;
      aw_addr  <= next_aw_addr;
      w_held   <= next_w_held;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bvalid_o <= next_bvalid;
      bresp_o  <= next_bresp;
      rvalid_o <= next_rvalid;
      rresp_o  <= next_rresp;
      rdata_o  <= next_rdata;
      d1_en    <= next_d1_en;
      d2_en    <= next_d2_en;
      mode     <= next_mode;
      d1_chr   <= next_d1_chr;
      d2_chr   <= next_d2_chr;
      pack_len <= next_pack_len;
      idle_ms  <= next_idle_ms;
    end
  end

  // Buffer is frozen while a packet drains; the sender is stalled meanwhile
  assign ser_ready_o = (state == ST_FILL);
  assign tx_valid_o  = (state == ST_SEND);
  assign tx_last_o   = (state == ST_SEND) && (rd_ptr == pkt_len - CNT_W'(1));
  assign ms_tick     = (div_cnt == DIV_W'(MS_CYCLES - 1));

  // Packer: trigger detection, release and drain
  always_comb begin
    next_state    = state;
    next_count    = count;
    next_rd_ptr   = rd_ptr;
    next_pkt_len  = pkt_len;
    next_extra    = extra;
    next_prev_d1  = prev_d1;
    next_idle_cnt = idle_cnt;
    next_div_cnt  = div_cnt;
    next_pkt_cnt  = pkt_cnt;
    next_reason   = reason;
    mem_re        = 1'b0;
    release_now   = 1'b0;
    rel_why       = 4'h0;
    rel_len       = count;
    acc = ser_valid_i && ser_ready_o;
    // Second delimiter alone counts as no delimiter at all
    hit = d1_en && (extra == 2'h0) &&
          (d2_en ? (prev_d1 && ser_data_i == d2_chr) : (ser_data_i == d1_chr));
    strip = hit && (mode == DPROC_STRIP);
    store = acc && !strip;
    cnt_new = count + CNT_W'(store) - CNT_W'(acc && strip && d2_en);
    case (state)
      ST_FILL: begin
        next_div_cnt = ms_tick ? '0 : div_cnt + DIV_W'(1);
        if (ms_tick && idle_cnt != '1) begin
          next_idle_cnt = idle_cnt + IDLE_W'(1);
        end
        if (acc) begin
          next_div_cnt  = '0;
          next_idle_cnt = '0;
          next_prev_d1  = (ser_data_i == d1_chr);
          next_count    = cnt_new;
          if (extra != 2'h0) begin
            next_extra = extra - 2'h1;
            rel_why[RSN_DELIM] = (extra == 2'h1);
          end else if (hit) begin
            case (mode)
              DPROC_ADD1: next_extra = 2'h1;
              DPROC_ADD2: next_extra = 2'h2;
              default:    rel_why[RSN_DELIM] = 1'b1;
            endcase
          end
          rel_why[RSN_LEN]  = (pack_len != '0) && (32'(cnt_new) == 32'(pack_len));
          rel_why[RSN_FULL] = (32'(cnt_new) == BUF_DEPTH);
          rel_len = cnt_new;
        end else if (idle_ms != '0 && count != '0 && idle_cnt >= idle_ms) begin
          rel_why[RSN_IDLE] = 1'b1;
        end
        release_now = (rel_why != 4'h0);
      end
      ST_FETCH: begin
        mem_re     = 1'b1;
        next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready_i) begin
          next_rd_ptr = rd_ptr + CNT_W'(1);
          next_state  = tx_last_o ? ST_FILL : ST_FETCH;
        end
      end
      default: next_state = ST_FILL;
    endcase
    if (release_now) begin
      next_reason   = rel_why;
      next_pkt_len  = rel_len;
      next_count    = '0;
      next_rd_ptr   = '0;
      next_extra    = 2'h0;
      next_prev_d1  = 1'b0;
      next_idle_cnt = '0;
      next_div_cnt  = '0;
      // A stripped delimiter alone makes an empty packet: nothing to send
      if (rel_len != '0) begin
        next_state   = ST_FETCH;
        next_pkt_cnt = pkt_cnt + PKT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_FILL;
      count    <= '0;
      rd_ptr   <= '0;
      pkt_len  <= '0;
      extra    <= 2'h0;
      prev_d1  <= 1'b0;
      idle_cnt <= '0;
      div_cnt  <= '0;
      pkt_cnt  <= '0;
      reason   <= 4'h0;
    end else begin
      state    <= next_state;
      count    <= next_count;
      rd_ptr   <= next_rd_ptr;
      pkt_len  <= next_pkt_len;
      extra    <= next_extra;
      prev_d1  <= next_prev_d1;
      idle_cnt <= next_idle_cnt;
      div_cnt  <= next_div_cnt;
      pkt_cnt  <= next_pkt_cnt;
      reason   <= next_reason;
    end
  end

  pack_buffer_mem #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .we_i      (store),
    .waddr_i   (count[AB_W-1:0]),
    .wdata_i   (ser_data_i),
    .re_i      (mem_re),
    .raddr_i   (rd_ptr[AB_W-1:0]),
    .rdata_o   (tx_data_o)
  );

  reset_vals_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(rst_i) |-> pack_len == '0 && idle_ms == '0 && !d1_en && !d2_en && mode == DPROC_PASS)
    else $error("settings not at reset values");
  len_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc && !strip && pack_len != '0 && 32'(count) + 1 == 32'(pack_len)) |=> state == ST_FETCH)
    else $error("packing length reached without release");
  full_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc && !strip && 32'(count) == BUF_DEPTH - 1) |=> state == ST_FETCH && reason[RSN_FULL])
    else $error("full buffer not released");
  single_delim_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc && d1_en && !d2_en && extra == 2'h0 && mode == DPROC_PASS && ser_data_i == d1_chr)
    |=> state == ST_FETCH && pkt_len == $past(count) + CNT_W'(1))
    else $error("delimiter match did not release");
  no_delim_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc && !d1_en && pack_len == '0 && 32'(count) < BUF_DEPTH - 1) |=> state == ST_FILL)
    else $error("release without any trigger");
  add_two_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc && hit && mode == DPROC_ADD2 && pack_len == '0 && 32'(count) < BUF_DEPTH - 3)
    |=> extra == 2'h2 && state == ST_FILL)
    else $error("append two did not wait");
  idle_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == ST_FILL && !acc && idle_ms == '0) |=> state == ST_FILL)
    else $error("release on silence with idle off");
  idle_restart_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    acc |=> idle_cnt == '0 && div_cnt == '0)
    else $error("idle timer not restarted");
  drain_order_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_valid_o && tx_ready_i && !tx_last_o) |=> state == ST_FETCH ##1 tx_valid_o && rd_ptr == $past(rd_ptr, 2) + CNT_W'(1))
    else $error("drain out of order");
  drain_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_valid_o && tx_ready_i && tx_last_o) |=> state == ST_FILL && count == '0 && ser_ready_o)
    else $error("buffer not emptied after packet");

endmodule
`default_nettype wire

// ### tb/pack_partner.sv
// Far-side model: serial byte source and network packet sink.
// Assumes the packer's single clock; each byte is held until ready is seen.
`timescale 1ns/10ps
`default_nettype none
module pack_partner (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Serial byte source
  output logic      [7:0] ser_data_o,
  output logic            ser_valid_o,
  input  wire logic       ser_ready_i,
  // Packet sink
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  int         lens[$];
  int         plen = 0;
  initial begin
    ser_data_o  = 8'h00;
    ser_valid_o = 1'b0;
  end
  // Random stalls keep the drain path honest
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= ($urandom % 4) != 0;
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_data_i);
        plen = plen + 1;
        if (tx_last_i) begin
          lens.push_back(plen);
          plen = 0;
        end
      end
    end
  end
  // Valid drops only after the last byte, so bursts stay back to back
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      ser_data_o  <= q[i];
      ser_valid_o <= 1'b1;
      #1;
      while (ser_ready_i !== 1'b1) begin
        @(posedge clk_sys_i);
        #1;
      end
      @(posedge clk_sys_i);
    end
    ser_valid_o <= 1'b0;
    ser_data_o  <= ~ser_data_o;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the serial data packer.
// Assumes a 16-byte buffer and a millisecond scaled to 10 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import packer_pkg::*;
  typedef logic [7:0] bq_t[$];
  localparam int DEPTH = 16;
  localparam int MSC   = 10;
  localparam int LIMIT = 20000;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  awaddr_i  = 8'h00;
  logic [7:0]  araddr_i  = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        awvalid_i = 1'b0;
  logic        wvalid_i  = 1'b0;
  logic        arvalid_i = 1'b0;
  logic [3:0]  wstrb_i   = 4'hF;
  logic        bready_i  = 1'b0;
  logic        rready_i  = 1'b0;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic        tx_valid_o, tx_last_o, tx_ready_i, ser_valid_i, ser_ready_o;
  logic [1:0]  bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [7:0]  ser_data_i, tx_data_o;
  int          bad_count = 0;
  int          checks    = 0;
  int          cyc       = 0;

  serial_data_packer #(.BUF_DEPTH(DEPTH), .MS_CYCLES(MSC)) u_dut (
    .clk_sys_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
    .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
    .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .ser_data_i, .ser_valid_i,
    .ser_ready_o, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i);
  pack_partner u_part (
    .clk_sys_i, .rst_i, .ser_data_o(ser_data_i), .ser_valid_o(ser_valid_i),
    .ser_ready_i(ser_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hung handshake ends up here instead of spinning forever
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Handshakes are judged in the quiet half of the cycle, acted on at the edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    while (!done) begin
      @(negedge clk_sys_i);
      ta   = awvalid_i && awready_o;
      tw   = wvalid_i && wready_o;
      done = bvalid_o === 1'b1;
      if (done) chk("bresp", {30'h0, bresp_o}, {30'h0, er});
      @(posedge clk_sys_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
      // Ready stays up until the edge that takes the response
      bready_i <= !done;
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tk, done;
    done = 1'b0;
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    while (!done) begin
      @(negedge clk_sys_i);
      tk   = arvalid_i && arready_o;
      done = rvalid_o === 1'b1;
      d    = rdata_o;
      r    = rresp_o;
      @(posedge clk_sys_i);
      if (tk) arvalid_i <= 1'b0;
      rready_i <= !done;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk("reg_read", d, e);
  endtask

  function automatic void fill(ref bq_t q, input int n);
    repeat (n) q.push_back(8'($urandom_range(32, 126)));
  endfunction

  function automatic bq_t exp_delim(bq_t q, int mode, int nd);
    if (mode == DPROC_STRIP) repeat (nd) void'(q.pop_back());
    return q;
  endfunction

  task automatic expect_pkt(input bq_t e);
    int n;
    while (u_part.lens.size() == 0) @(posedge clk_sys_i);
    n = u_part.lens.pop_front();
    chk("pkt_len", 32'(n), 32'(e.size()));
    for (int i = 0; i < n && i < e.size(); i++) begin
      chk("pkt_byte", {24'h0, u_part.got[i]}, {24'h0, e[i]});
    end
    repeat (n) void'(u_part.got.pop_front());
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    bq_t         q, s;
    void'($urandom(32'h5B299987));
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_chk(CTRL_OFS, 32'h0);
    rd_chk(DELIM_OFS, 32'h0);
    rd_chk(PACK_LEN_OFS, 32'h0);
    rd_chk(IDLE_MS_OFS, 32'h0);
    axw(PACK_LEN_OFS, 32'h400, RESP_OKAY);
    rd_chk(PACK_LEN_OFS, 32'h400);
    axw(IDLE_MS_OFS, 32'hFFFF, RESP_OKAY);
    rd_chk(IDLE_MS_OFS, 32'hFFFF);
    axw(8'h1C, 32'h1, RESP_SLVERR);
    axr(8'h1C, d, r);
    chk("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    // Second delimiter alone is no delimiter, so strip must not act
    axw(PACK_LEN_OFS, 32'h0, RESP_OKAY);
    axw(IDLE_MS_OFS, 32'h0, RESP_OKAY);
    axw(DELIM_OFS, 32'h770D, RESP_OKAY);
    // Only lane 1 strobed: the first delimiter must survive
    wstrb_i <= 4'h2;
    axw(DELIM_OFS, 32'h0A99, RESP_OKAY);
    wstrb_i <= 4'hF;
    rd_chk(DELIM_OFS, 32'h0A0D);
    axw(CTRL_OFS, 32'h32, RESP_OKAY);
    fill(q, 3);
    q.push_back(8'h0A);
    q.push_back(8'h0D);
    fill(q, 5);
    u_part.send(q);
    repeat (100) @(posedge clk_sys_i);
    chk("early_pkts", 32'(u_part.lens.size()), 32'h0);
    fill(s, DEPTH - 10);
    u_part.send(s);
    expect_pkt({q, s});
    axw(CTRL_OFS, 32'h0, RESP_OKAY);
    axw(PACK_LEN_OFS, 32'h5, RESP_OKAY);
    q.delete();
    fill(q, 10);
    u_part.send(q);
    expect_pkt(q[0:4]);
    expect_pkt(q[5:9]);
    // Idle, empty, last reason length
    rd_chk(STATUS_OFS, 32'h0010_0000);
    axw(PACK_LEN_OFS, 32'h0, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        axw(CTRL_OFS, {26'h0, m[1:0], 2'h0, b[0], 1'b1}, RESP_OKAY);
        q.delete();
        fill(q, 2);
        if (b) begin
          q.push_back(8'h0A);
          q.push_back(8'h0D);
          fill(q, 1);
          q.push_back(8'h0D);
        end
        q.push_back(b ? 8'h0A : 8'h0D);
        fill(q, m == 1 ? 1 : m == 2 ? 2 : 0);
        u_part.send(q);
        expect_pkt(exp_delim(q, m, b + 1));
      end
    end
    // Idle release: gaps shorter than the timeout must restart the timer
    axw(CTRL_OFS, 32'h0, RESP_OKAY);
    axw(IDLE_MS_OFS, 32'h3, RESP_OKAY);
    q.delete();
    s.delete();
    fill(s, 1);
    u_part.send(s);
    repeat (20) @(posedge clk_sys_i);
    fill(q, 2);
    u_part.send(q);
    repeat (25) @(posedge clk_sys_i);
    chk("idle_early", 32'(u_part.lens.size()), 32'h0);
    expect_pkt({s, q});
    // One full, two by length, eight by delimiter, one by idle
    rd_chk(PKT_CNT_OFS, 32'hC);
    // Reset in mid-run must bring the idle time, control and packet count back
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_chk(IDLE_MS_OFS, 32'h0);
    rd_chk(CTRL_OFS, 32'h0);
    rd_chk(PKT_CNT_OFS, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
